//--- hdl/global_ctrl_pkg.sv
// Constants, types and helpers shared by the global control register slice
package global_ctrl_pkg;

    localparam int NUM_PORTS = 5;
    localparam int QUOTA_W = 11;
    localparam int VID_W = 12;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PORT_IDX_W = 3;

    // Register offsets
    localparam logic [7:0] ADDR_MIRROR_STORM_CTRL = 8'h05;
    localparam logic [7:0] ADDR_PORT5_LINK_AND_STORM_HIGH = 8'h06;
    localparam logic [7:0] ADDR_STORM_RATE_LOW = 8'h07;
    localparam logic [7:0] ADDR_STATS_COUNTER_CONTROL = 8'h08;

    // Mirror and storm control fields
    localparam int BIT_MIRROR_BOTH = 0;
    localparam int BIT_MCAST_EXCL = 6;
    localparam logic RST_MIRROR_BOTH = 1'h0;
    localparam logic RST_MCAST_EXCL = 1'h1;

    // Port-5 link and storm high fields
    localparam int BIT_BACK_PRESSURE = 7;
    localparam int BIT_HALF_DUPLEX = 6;
    localparam int BIT_FLOW_CTRL = 5;
    localparam int BIT_SLOW_SPEED = 4;
    localparam int BIT_NULL_VID_REPL = 3;
    localparam int STORM_HI_MSB = 2;
    localparam int STORM_HI_W = 3;
    localparam logic [7:0] RST_PORT5_LINK_AND_STORM_HIGH = 8'h00;
    localparam logic [7:0] RST_STORM_RATE_LOW = 8'h4a;

    // Counter control fields
    localparam int BIT_FLUSH = 7;
    localparam int BIT_FREEZE = 6;
    localparam int BIT_STATS_RSVD = 5;
    localparam int ENABLE_MSB = 4;
    localparam logic [7:0] RST_STATS_COUNTER_CONTROL = 8'h00;

    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Storm period timing
    localparam int CLK_HZ = 40_000_000;
    localparam int STORM_PERIOD_FAST_MS = 50;
    localparam int STORM_PERIOD_SLOW_MS = 500;
    localparam int STORM_FAST_CYCLES = STORM_PERIOD_FAST_MS * (CLK_HZ / 1000);
    localparam int STORM_SLOW_CYCLES = STORM_PERIOD_SLOW_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0] {
        FLUSH_IDLE = 2'h0,
        FLUSH_RUN = 2'h1,
        FLUSH_FINISH = 2'h3
    } flush_state_e;

    // One-hot select of a port numbered from 1; zero for an illegal number
    function automatic logic [NUM_PORTS-1:0] port_sel(
        input logic [PORT_IDX_W-1:0] num
    );
        logic [NUM_PORTS-1:0] sel;
        sel = '0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (int'(num) == i + 1) begin
                sel[i] = 1'b1;
            end
        end
        return sel;
    endfunction

endpackage

//--- hdl/storm_period_timer.sv
// Free-running period timer giving one tick per storm measurement period
`timescale 1ns/1ps
module storm_period_timer #(
    parameter int CYCLES = 2
) (
    input wire logic mclk,
    input wire logic sys_rst,
    output logic tick
);

    localparam int CNT_W = $clog2(CYCLES);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    generate
        if (CYCLES < 2) begin : g_bad_cycles
            $error("storm_period_timer needs CYCLES of at least 2");
        end
    endgenerate

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic at_end;

    assign at_end = (count_r == LAST);
    assign count_nxt = at_end ? '0 : count_r + CNT_W'(1);
    assign tick = at_end;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule

//--- hdl/storm_quota_counter.sv
// Per-port count of broadcast-class blocks within the current period
`timescale 1ns/1ps
module storm_quota_counter #(
    parameter int QUOTA_W = 11
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic period_tick,
    input wire logic count_blk,
    input wire logic [QUOTA_W-1:0] quota,
    output logic over_quota
);

    generate
        if (QUOTA_W < 1) begin : g_bad_width
            $error("storm_quota_counter needs a positive QUOTA_W");
        end
    endgenerate

    logic [QUOTA_W-1:0] count_r;
    logic [QUOTA_W-1:0] count_nxt;
    logic [QUOTA_W-1:0] base;

    assign over_quota = (count_r >= quota);
    // Period boundary restarts the count
    assign base = period_tick ? '0 : count_r;
    assign count_nxt = (count_blk && !over_quota) ? base + QUOTA_W'(1) : base;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule

//--- hdl/switch_global_control_bank.sv
// Global control register slice: mirroring, port-5 link, storm, counters
`timescale 1ns/1ps
module switch_global_control_bank #(
    parameter int STORM_FAST_CYCLES = global_ctrl_pkg::STORM_FAST_CYCLES,
    parameter int STORM_SLOW_CYCLES = global_ctrl_pkg::STORM_SLOW_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    // Host register port
    input wire logic [global_ctrl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [global_ctrl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [global_ctrl_pkg::DATA_W-1:0] reg_rdata,
    // Port mirroring
    input wire logic mirror_src_hit,
    input wire logic mirror_dst_hit,
    output logic mirror_take,
    // Port-5 media interface settings
    output logic uplink_back_pressure_en,
    output logic uplink_half_duplex,
    output logic uplink_flow_ctrl_en,
    output logic uplink_slow_speed,
    // Null VID replacement
    input wire logic vid_valid,
    input wire logic [global_ctrl_pkg::VID_W-1:0] vid_in,
    input wire logic [global_ctrl_pkg::VID_W-1:0] vid_port_default,
    output logic vid_out_valid,
    output logic [global_ctrl_pkg::VID_W-1:0] vid_out,
    // Storm limiter
    input wire logic [global_ctrl_pkg::NUM_PORTS-2:0] port_slow_speed,
    input wire logic storm_blk_valid,
    input wire logic [global_ctrl_pkg::PORT_IDX_W-1:0] storm_blk_port,
    input wire logic storm_da_all_ones,
    input wire logic storm_da_group,
    output logic storm_drop,
    // Statistics counter control
    output logic [global_ctrl_pkg::NUM_PORTS-1:0] stats_flush,
    input wire logic stats_flush_done,
    output logic [global_ctrl_pkg::NUM_PORTS-1:0] stats_freeze
);

    localparam int NP = global_ctrl_pkg::NUM_PORTS;
    localparam int QW = global_ctrl_pkg::QUOTA_W;
    localparam int DW = global_ctrl_pkg::DATA_W;
    localparam int VW = global_ctrl_pkg::VID_W;

    generate
        if (STORM_FAST_CYCLES < 2 || STORM_SLOW_CYCLES < 2) begin : g_bad_period
            $error("storm periods must be at least 2 cycles");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    logic hit_mirror;
    logic hit_port5;
    logic hit_storm_lo;
    logic hit_stats;

    assign hit_mirror = (reg_addr == global_ctrl_pkg::ADDR_MIRROR_STORM_CTRL);
    assign hit_port5 =
        (reg_addr == global_ctrl_pkg::ADDR_PORT5_LINK_AND_STORM_HIGH);
    assign hit_storm_lo = (reg_addr == global_ctrl_pkg::ADDR_STORM_RATE_LOW);
    assign hit_stats =
        (reg_addr == global_ctrl_pkg::ADDR_STATS_COUNTER_CONTROL);

    logic wr_mirror;
    logic wr_port5;
    logic wr_storm_lo;
    logic wr_stats;

    assign wr_mirror = reg_wr && hit_mirror;
    assign wr_port5 = reg_wr && hit_port5;
    assign wr_storm_lo = reg_wr && hit_storm_lo;
    assign wr_stats = reg_wr && hit_stats;

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic mirror_both_r;
    logic mcast_excl_r;
    logic [DW-1:0] port5_r;
    logic [DW-1:0] storm_lo_r;
    logic flush_r;
    logic freeze_r;
    logic [NP-1:0] enable_r;

    logic flush_nxt;
    logic flush_done_now;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mirror_both_r <= global_ctrl_pkg::RST_MIRROR_BOTH;
            mcast_excl_r <= global_ctrl_pkg::RST_MCAST_EXCL;
        end else if (wr_mirror) begin
            mirror_both_r <= reg_wdata[global_ctrl_pkg::BIT_MIRROR_BOTH];
            mcast_excl_r <= reg_wdata[global_ctrl_pkg::BIT_MCAST_EXCL];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            port5_r <= global_ctrl_pkg::RST_PORT5_LINK_AND_STORM_HIGH;
            storm_lo_r <= global_ctrl_pkg::RST_STORM_RATE_LOW;
        end else begin
            if (wr_port5) begin
                port5_r <= reg_wdata;
            end
            if (wr_storm_lo) begin
                storm_lo_r <= reg_wdata;
            end
        end
    end

    // A write of one in the finishing cycle wins over the self-clear
    assign flush_nxt = (wr_stats && reg_wdata[global_ctrl_pkg::BIT_FLUSH])
        || (flush_r && !flush_done_now);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flush_r <=
                global_ctrl_pkg::RST_STATS_COUNTER_CONTROL[
                    global_ctrl_pkg::BIT_FLUSH];
            freeze_r <=
                global_ctrl_pkg::RST_STATS_COUNTER_CONTROL[
                    global_ctrl_pkg::BIT_FREEZE];
            enable_r <=
                global_ctrl_pkg::RST_STATS_COUNTER_CONTROL[
                    global_ctrl_pkg::ENABLE_MSB:0];
        end else begin
            flush_r <= flush_nxt;
            if (wr_stats) begin
                freeze_r <= reg_wdata[global_ctrl_pkg::BIT_FREEZE];
                enable_r <= reg_wdata[global_ctrl_pkg::ENABLE_MSB:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    logic [DW-1:0] mirror_rd;
    logic [DW-1:0] stats_rd;
    logic [DW-1:0] rd_mux;
    logic [DW-1:0] rdata_r;

    always_comb begin
        mirror_rd = '0;
        mirror_rd[global_ctrl_pkg::BIT_MIRROR_BOTH] = mirror_both_r;
        mirror_rd[global_ctrl_pkg::BIT_MCAST_EXCL] = mcast_excl_r;
    end

    always_comb begin
        stats_rd = '0;
        stats_rd[global_ctrl_pkg::BIT_FLUSH] = flush_r;
        stats_rd[global_ctrl_pkg::BIT_FREEZE] = freeze_r;
        stats_rd[global_ctrl_pkg::ENABLE_MSB:0] = enable_r;
        stats_rd[global_ctrl_pkg::BIT_STATS_RSVD] = 1'b0;
    end

    assign rd_mux = hit_mirror ? mirror_rd :
                    hit_port5 ? port5_r :
                    hit_storm_lo ? storm_lo_r :
                    hit_stats ? stats_rd :
                    global_ctrl_pkg::READ_UNMAPPED;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= reg_rd ? rd_mux : '0;
        end
    end

    assign reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Mirroring and port-5 link settings

    assign mirror_take = mirror_both_r ?
        (mirror_src_hit && mirror_dst_hit) :
        (mirror_src_hit || mirror_dst_hit);

    assign uplink_back_pressure_en =
        port5_r[global_ctrl_pkg::BIT_BACK_PRESSURE];
    assign uplink_half_duplex = port5_r[global_ctrl_pkg::BIT_HALF_DUPLEX];
    assign uplink_flow_ctrl_en = port5_r[global_ctrl_pkg::BIT_FLOW_CTRL];
    assign uplink_slow_speed = port5_r[global_ctrl_pkg::BIT_SLOW_SPEED];

    ////////////////////////////////////////////////////////////////////////
    // Null VID replacement

    logic vid_is_null;
    logic [VW-1:0] vid_nxt;
    logic [VW-1:0] vid_out_r;
    logic vid_out_valid_r;

    assign vid_is_null = (vid_in == '0);
    assign vid_nxt =
        (vid_is_null && port5_r[global_ctrl_pkg::BIT_NULL_VID_REPL]) ?
        vid_port_default : vid_in;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            vid_out_r <= '0;
            vid_out_valid_r <= 1'b0;
        end else begin
            vid_out_valid_r <= vid_valid;
            if (vid_valid) begin
                vid_out_r <= vid_nxt;
            end
        end
    end

    assign vid_out = vid_out_r;
    assign vid_out_valid = vid_out_valid_r;

    ////////////////////////////////////////////////////////////////////////
    // Broadcast storm limiter

    logic [QW-1:0] quota;
    logic tick_fast;
    logic tick_slow;
    logic [NP-1:0] port_slow;
    logic [NP-1:0] port_tick;
    logic [NP-1:0] blk_sel;
    logic [NP-1:0] over_quota;
    logic storm_class;
    logic storm_drop_r;

    assign quota = {port5_r[global_ctrl_pkg::STORM_HI_MSB:0], storm_lo_r};

    // Ports 1 to 4 report their speed; port 5 uses its own setting
    assign port_slow = {uplink_slow_speed, port_slow_speed};

    storm_period_timer #(
        .CYCLES(STORM_FAST_CYCLES)
    ) u_fast_timer (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(tick_fast)
    );

    storm_period_timer #(
        .CYCLES(STORM_SLOW_CYCLES)
    ) u_slow_timer (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(tick_slow)
    );

    // Each port restarts on the period that matches its speed
    assign port_tick = (port_slow & {NP{tick_slow}})
        | (~port_slow & {NP{tick_fast}});

    assign storm_class = storm_da_all_ones
        || (!mcast_excl_r && storm_da_group);

    assign blk_sel = (storm_blk_valid && storm_class) ?
        global_ctrl_pkg::port_sel(storm_blk_port) : '0;

    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_port
            storm_quota_counter #(
                .QUOTA_W(QW)
            ) u_quota (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .period_tick(port_tick[gp]),
                .count_blk(blk_sel[gp]),
                .quota(quota),
                .over_quota(over_quota[gp])
            );
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            storm_drop_r <= 1'b0;
        end else begin
            storm_drop_r <= |(blk_sel & over_quota);
        end
    end

    assign storm_drop = storm_drop_r;

    ////////////////////////////////////////////////////////////////////////
    // Statistics flush sequencer and freeze

    global_ctrl_pkg::flush_state_e flush_state_r;
    global_ctrl_pkg::flush_state_e flush_state_nxt;
    logic flush_run_end;

    assign flush_run_end = stats_flush_done || (enable_r == '0);
    assign flush_done_now = (flush_state_r == global_ctrl_pkg::FLUSH_FINISH);

    always_comb begin
        flush_state_nxt = flush_state_r;
        unique case (flush_state_r)
            global_ctrl_pkg::FLUSH_IDLE: begin
                if (flush_r) begin
                    flush_state_nxt = global_ctrl_pkg::FLUSH_RUN;
                end
            end
            global_ctrl_pkg::FLUSH_RUN: begin
                if (flush_run_end) begin
                    flush_state_nxt = global_ctrl_pkg::FLUSH_FINISH;
                end
            end
            global_ctrl_pkg::FLUSH_FINISH: begin
                flush_state_nxt = global_ctrl_pkg::FLUSH_IDLE;
            end
            default: begin
                flush_state_nxt = global_ctrl_pkg::FLUSH_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flush_state_r <= global_ctrl_pkg::FLUSH_IDLE;
        end else begin
            flush_state_r <= flush_state_nxt;
        end
    end

    assign stats_flush = (flush_state_r == global_ctrl_pkg::FLUSH_RUN) ?
        enable_r : '0;
    assign stats_freeze = {NP{freeze_r}} & enable_r;

endmodule

//--- test/stats_counter_model.sv
// Statistics counter model answering flush requests after a set delay
`timescale 1ns/1ps
module stats_counter_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [4:0] stats_flush,
    input wire logic [4:0] stats_freeze,
    input wire logic [7:0] done_delay,
    output logic stats_flush_done
);
    logic [7:0] wait_r;
    logic [15:0] cnt_r [5];
    always_ff @(posedge mclk) begin
        stats_flush_done <= 1'b0;
        if (sys_rst || stats_flush == 5'h00 || stats_flush_done) begin
            wait_r <= 8'h00;
        end else if (wait_r == done_delay) begin
            stats_flush_done <= 1'b1;
        end else begin
            wait_r <= wait_r + 8'h01;
        end
        for (int i = 0; i < 5; i++) begin
            if (stats_flush[i]) begin
                cnt_r[i] <= 16'h0000;
            end else if (!stats_freeze[i]) begin
                cnt_r[i] <= cnt_r[i] + 16'h0001;
            end
        end
    end
endmodule

//--- test/switch_global_control_bank_properties.sv
// Port-level checks for the global control register slice
`timescale 1ns/1ps
module switch_global_control_bank_properties (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic mirror_src_hit,
    input wire logic mirror_dst_hit,
    input wire logic mirror_take,
    input wire logic uplink_back_pressure_en,
    input wire logic uplink_half_duplex,
    input wire logic uplink_flow_ctrl_en,
    input wire logic uplink_slow_speed,
    input wire logic vid_valid,
    input wire logic [11:0] vid_in,
    input wire logic vid_out_valid,
    input wire logic [11:0] vid_out,
    input wire logic storm_blk_valid,
    input wire logic storm_drop,
    input wire logic [4:0] stats_flush,
    input wire logic stats_flush_done,
    input wire logic [4:0] stats_freeze
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    logic [3:0] uplink;
    assign uplink = {uplink_back_pressure_en, uplink_half_duplex,
        uplink_flow_ctrl_en, uplink_slow_speed};
    ////////////////////////////////////////////////////////////////////////
    a_mirror_both: assert property (
        mirror_src_hit && mirror_dst_hit |-> mirror_take)
        else $error("mirror missed on double hit");
    a_mirror_none: assert property (
        !mirror_src_hit && !mirror_dst_hit |-> !mirror_take)
        else $error("mirror taken without hit");
    a_uplink_write: assert property (
        reg_wr && reg_addr == 8'h06 |=> uplink == $past(reg_wdata[7:4]))
        else $error("uplink settings differ from write");
    a_rsvd_zero: assert property (
        reg_rd && reg_addr == 8'h08 |=> !reg_rdata[5])
        else $error("reserved counter bit read as one");
    a_quota_low: assert property (
        reg_wr && reg_addr == 8'h07 ##1 reg_rd && reg_addr == 8'h07
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("quota low byte readback wrong");
    a_vid_pass: assert property (
        vid_valid && vid_in != 12'h000
        |=> vid_out_valid && vid_out == $past(vid_in))
        else $error("non-null vid altered");
    a_freeze_write: assert property (
        reg_wr && reg_addr == 8'h08 |=> stats_freeze ==
        ($past(reg_wdata[6]) ? $past(reg_wdata[4:0]) : 5'h00))
        else $error("freeze mask wrong");
    a_flush_start: assert property (
        reg_wr && reg_addr == 8'h08 && reg_wdata[7] && stats_flush == 5'h00
        ##1 !reg_wr |=> stats_flush == $past(reg_wdata[4:0], 2))
        else $error("flush mask wrong");
    a_flush_hold: assert property (
        stats_flush != 5'h00 && !stats_flush_done && !reg_wr
        |=> $stable(stats_flush))
        else $error("flush dropped before done");
    a_flush_end: assert property (
        stats_flush != 5'h00 && stats_flush_done |=> stats_flush == 5'h00 [*2])
        else $error("flush not ended after done");
    a_storm_quiet: assert property (
        !storm_blk_valid |=> !storm_drop)
        else $error("drop without block");
endmodule

bind switch_global_control_bank switch_global_control_bank_properties
    i_props (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mirror_src_hit(mirror_src_hit),
    .mirror_dst_hit(mirror_dst_hit), .mirror_take(mirror_take),
    .uplink_back_pressure_en(uplink_back_pressure_en),
    .uplink_half_duplex(uplink_half_duplex),
    .uplink_flow_ctrl_en(uplink_flow_ctrl_en),
    .uplink_slow_speed(uplink_slow_speed), .vid_valid(vid_valid),
    .vid_in(vid_in), .vid_out_valid(vid_out_valid), .vid_out(vid_out),
    .storm_blk_valid(storm_blk_valid), .storm_drop(storm_drop),
    .stats_flush(stats_flush), .stats_flush_done(stats_flush_done),
    .stats_freeze(stats_freeze));

//--- test/tb_switch_global_control_bank.sv
// Self-checking bench for the global control register slice
`timescale 1ns/1ps
module tb_switch_global_control_bank;
    localparam int FAST = 40;
    localparam int SLOW = 400;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic mirror_src_hit = 1'b0, mirror_dst_hit = 1'b0, mirror_take;
    logic uplink_back_pressure_en, uplink_half_duplex;
    logic uplink_flow_ctrl_en, uplink_slow_speed;
    wire [3:0] uplink = {uplink_back_pressure_en, uplink_half_duplex,
        uplink_flow_ctrl_en, uplink_slow_speed};
    logic vid_valid = 1'b0, vid_out_valid;
    logic [11:0] vid_in = 12'h000, vid_port_default = 12'h000, vid_out;
    logic [3:0] port_slow_speed = 4'h0;
    logic storm_blk_valid = 1'b0, storm_da_all_ones = 1'b0;
    logic storm_da_group = 1'b0, storm_drop;
    logic [2:0] storm_blk_port = 3'h0;
    logic [4:0] stats_flush, stats_freeze;
    logic stats_flush_done;
    logic [7:0] done_delay = 8'h00;
    logic [31:0] seed = 32'hfbc29732;
    int error_cnt = 0, compares = 0, cyc = 0;
    int m [256];

    always #12.5 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    switch_global_control_bank #(.STORM_FAST_CYCLES(FAST),
        .STORM_SLOW_CYCLES(SLOW)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mirror_src_hit(mirror_src_hit), .mirror_dst_hit(mirror_dst_hit),
        .mirror_take(mirror_take),
        .uplink_back_pressure_en(uplink_back_pressure_en),
        .uplink_half_duplex(uplink_half_duplex),
        .uplink_flow_ctrl_en(uplink_flow_ctrl_en),
        .uplink_slow_speed(uplink_slow_speed), .vid_valid(vid_valid),
        .vid_in(vid_in), .vid_port_default(vid_port_default),
        .vid_out_valid(vid_out_valid), .vid_out(vid_out),
        .port_slow_speed(port_slow_speed), .storm_blk_valid(storm_blk_valid),
        .storm_blk_port(storm_blk_port), .storm_da_all_ones(storm_da_all_ones),
        .storm_da_group(storm_da_group), .storm_drop(storm_drop),
        .stats_flush(stats_flush), .stats_flush_done(stats_flush_done),
        .stats_freeze(stats_freeze));

    stats_counter_model i_cnt (.mclk(mclk), .sys_rst(sys_rst),
        .stats_flush(stats_flush), .stats_freeze(stats_freeze),
        .done_delay(done_delay), .stats_flush_done(stats_flush_done));

    ////////////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task print_verdict();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Reference register file: stored bits only, unmapped stays zero
    function automatic void mw(input int a, input int d);
        case (a)
            5: m[5] = d & 'h41;
            6, 7: m[a] = d;
            8: m[8] = d & 'hdf;
            default: ;
        endcase
    endfunction

    task op(input logic w, input logic r, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, a, d);
        mw(a, d);
        op(1'b0, 1'b0, a, 8'h00);
    endtask

    task rd(input logic [7:0] a);
        op(1'b0, 1'b1, a, 8'h00);
        op(1'b0, 1'b0, a, 8'h00);
        @(negedge mclk);
        chk("readback", reg_rdata, m[a]);
    endtask

    task blk(input logic [2:0] p, input logic ones, input logic grp,
        output logic d);
        @(posedge mclk);
        storm_blk_valid <= 1'b1;
        storm_blk_port <= p;
        storm_da_all_ones <= ones;
        storm_da_group <= grp;
        @(posedge mclk);
        storm_blk_valid <= 1'b0;
        @(negedge mclk);
        d = storm_drop;
    endtask

    // Saturate a port, then return the cycle of its first accepted block
    task probe(input logic [2:0] p, output int t);
        logic d;
        bit sat;
        sat = 0;
        t = -1;
        for (int i = 0; i < 600 && t < 0; i++) begin
            blk(p, 1'b1, 1'b0, d);
            if (d) sat = 1;
            else if (sat) t = cyc;
        end
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        $display("watchdog expired");
        print_verdict();
    end

    initial begin
        logic d;
        int t0, t1;
        logic [11:0] vi, vd;
        logic [31:0] r;
        logic [7:0] a, wd;
        logic [4:0] en [3];
        int dl [3];
        en = '{5'h11, 5'h0e, 5'h00};
        dl = '{0, 20, 5};
        m[5] = 'h40;
        m[7] = 'h4a;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 5; i < 10; i++) rd(i[7:0]);
        chk("uplink reset", uplink, 0);
        $display("test reset done");
        wr(8'h07, 8'h03);
        probe(3'h2, t0);
        probe(3'h2, t1);
        chk("fast period", t1 - t0, FAST);
        for (int i = 0; i < 5; i++) begin
            blk(3'h1, 1'b1, 1'b0, d);
            chk("storm drop", d, i >= 3);
        end
        blk(3'h1, 1'b0, 1'b1, d);
        chk("group excluded", d, 0);
        wr(8'h05, 8'h00);
        blk(3'h1, 1'b0, 1'b1, d);
        chk("group limited", d, 1);
        wr(8'h07, 8'h00);
        blk(3'h5, 1'b1, 1'b0, d);
        chk("zero quota", d, 1);
        wr(8'h06, 8'h01);
        blk(3'h4, 1'b1, 1'b0, d);
        chk("quota high bits", d, 0);
        wr(8'h06, 8'h00);
        wr(8'h07, 8'h03);
        @(posedge mclk);
        port_slow_speed <= 4'h4;
        probe(3'h3, t0);
        probe(3'h3, t1);
        chk("slow period", t1 - t0, SLOW);
        $display("test storm done");
        for (int k = 0; k < 3; k++) begin
            done_delay <= dl[k][7:0];
            op(1'b1, 1'b0, 8'h08, {3'h4, en[k]});
            op(1'b0, 1'b0, 8'h08, 8'h00);
            @(posedge mclk);
            @(negedge mclk);
            chk("flush mask", stats_flush, en[k]);
            m[8] = 'h80 | en[k];
            if (dl[k] > 10) rd(8'h08);
            for (int i = 0; i < 100 && stats_flush !== 5'h00; i++) begin
                @(negedge mclk);
            end
            chk("flush end", stats_flush, 0);
            m[8] = en[k];
            repeat (2) @(posedge mclk);
            rd(8'h08);
        end
        $display("test flush done");
        for (int i = 0; i < 40; i++) begin
            r = xs();
            a = r[3] ? 8'h05 + r[1:0] : r[15:8];
            wd = r[23:16];
            if (a == 8'h08) wd[7] = 1'b0;
            op(1'b1, 1'b0, a, wd);
            mw(a, wd);
            rd(a);
            chk("uplink", uplink, m[6] >> 4);
            chk("freeze", stats_freeze,
                m[8][6] ? m[8] & 31 : 0);
        end
        $display("test random registers done");
        for (int md = 0; md < 2; md++) begin
            wr(8'h05, md[7:0]);
            for (int c = 0; c < 4; c++) begin
                @(posedge mclk);
                mirror_src_hit <= c[0];
                mirror_dst_hit <= c[1];
                @(negedge mclk);
                chk("mirror", mirror_take, md ? c == 3 : c != 0);
            end
        end
        $display("test mirror done");
        for (int k = 0; k < 4; k++) begin
            wr(8'h06, {4'h0, k[1], 3'h0});
            r = xs();
            vi = k[0] ? r[11:0] | 12'h001 : 12'h000;
            vd = r[27:16];
            @(posedge mclk);
            vid_valid <= 1'b1;
            vid_in <= vi;
            vid_port_default <= vd;
            @(posedge mclk);
            vid_valid <= 1'b0;
            @(negedge mclk);
            chk("vid valid", vid_out_valid, 1);
            chk("vid", vid_out, (k[1] && vi == 0) ? vd : vi);
        end
        $display("test vid done");
        print_verdict();
    end
endmodule
